// File: rtl/lsg_regs.sv
// axi4-lite register bank: virtual line offset, split screen, colour tables, general pins
//
// Operation
// - a non-zero line offset adds that many words between one display line and the next.
// - the line offset is forced to zero while rotated mode is on.
// - screen 1 height is ten bits, low byte in one register and bits 9-8 in bits 1-0 of the next.
// - in landscape with height n below panel size, lines 0..n show screen 1 and the rest screen 2.
// - three colour tables each hold 256 four-bit entries.
// - the 8-bit table index register is the pointer for the data port.
// - writing the index register points at the red entry of that index.
// - each data port access steps red, green, blue, then red at the next index.
// - red and green writes are staged and the triple commits on the blue write.
// - table data sits in bits 7-4 of the data port, bits 3-0 read zero.
// - a clear direction bit makes the pin an input readable in the value register.
// - a set direction bit drives the pin from the value register.
// - pins in use as upper panel data ignore direction and value.
// - rotate bit 7 selects rotated mode and 0 landscape.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module lsg_regs
    import lsg_pkg::*;
(
    input  wire logic        sys_clk_in,             // system clock, 125 MHz
    input  wire logic        rst_n_in,               // sync reset, active low
    input  wire logic        s_axi_awvalid_in,       // write address valid
    output logic             s_axi_awready_out,      // write address ready
    input  wire logic [7:0]  s_axi_awaddr_in,        // write byte address
    input  wire logic        s_axi_wvalid_in,        // write data valid
    output logic             s_axi_wready_out,       // write data ready
    input  wire logic [31:0] s_axi_wdata_in,         // write data
    input  wire logic [3:0]  s_axi_wstrb_in,         // byte strobes
    output logic             s_axi_bvalid_out,       // write response valid
    input  wire logic        s_axi_bready_in,        // write response ready
    output logic      [1:0]  s_axi_bresp_out,        // write response
    input  wire logic        s_axi_arvalid_in,       // read address valid
    output logic             s_axi_arready_out,      // read address ready
    input  wire logic [7:0]  s_axi_araddr_in,        // read byte address
    output logic             s_axi_rvalid_out,       // read data valid
    input  wire logic        s_axi_rready_in,        // read data ready
    output logic      [31:0] s_axi_rdata_out,        // read data
    output logic      [1:0]  s_axi_rresp_out,        // read response
    input  wire logic [9:0]  disp_line_in,           // panel line being fetched
    output logic      [7:0]  line_gap_out,           // words skipped between lines
    output logic             rotate_en_out,          // rotated mode active
    output logic             screen2_sel_out,        // line belongs to screen 2
    input  wire logic [7:0]  pix_index_in,           // colour lookup index
    output logic      [3:0]  pix_red_out,            // red lookup result
    output logic      [3:0]  pix_green_out,          // green lookup result
    output logic      [3:0]  pix_blue_out,           // blue lookup result
    input  wire logic [4:0]  gpio_in,                // general pin levels
    output logic      [4:0]  gpio_out,               // general pin drive values
    output logic      [4:0]  gpio_oe_out,            // general pin enables
    output logic             panel_data_upper_bits_en_out  // pins 3-0 carry panel data
);
    lsg_lut_if lut_link ();

    lsg_wr_state_e wr_state, next_wr_state;
    lsg_rd_state_e rd_state, next_rd_state;
    logic          aw_held, next_aw_held;
    logic [7:0]    aw_addr, next_aw_addr;
    logic          w_held, next_w_held;
    logic [7:0]    w_byte, next_w_byte;
    logic          w_strb0, next_w_strb0;
    logic [1:0]    bresp, next_bresp;
    logic [31:0]   rdata, next_rdata;
    logic [1:0]    rresp, next_rresp;

    logic [7:0]    cur_addr;
    logic [7:0]    cur_byte;
    logic          cur_strb0;
    logic          do_write;
    logic          do_read;
    logic          wr_map;
    logic          rd_map;
    logic          wr_hit;

    logic [9:0]    panel_size, next_panel_size;
    logic [7:0]    line_offset, next_line_offset;
    logic [9:0]    h1, next_h1;
    logic [7:0]    ct_index, next_ct_index;
    logic [4:0]    pin_dir, next_pin_dir;
    logic [4:0]    pin_val, next_pin_val;
    logic [7:0]    rotate, next_rotate;
    logic          upper_en, next_upper_en;
    logic [4:0]    pin_status;
    logic [4:0]    pin_own;

    logic [7:0]    next_line_gap;
    logic          next_screen2;
    logic [4:0]    next_gpio;
    logic [4:0]    next_gpio_oe;

    // address is mapped when word aligned and one of the known indices
    function automatic logic is_mapped(input logic [7:0] a);
        logic [5:0] i;
        i = a[7:2];
        is_mapped = (a[1:0] == 2'b00) &&
                    (i == IDX_PANEL_LO || i == IDX_PANEL_HI || i == IDX_LINE_OFFSET ||
                     i == IDX_H1_LO || i == IDX_H1_HI || i == IDX_CT_INDEX ||
                     i == IDX_CT_DATA || i == IDX_PIN_DIR || i == IDX_PIN_VAL ||
                     i == IDX_ROTATE || i == IDX_PANEL_CFG);
    endfunction : is_mapped

    // bus handshakes: address and data are taken in either order
    assign s_axi_awready_out = (wr_state == LSG_W_IDLE) && !aw_held;
    assign s_axi_wready_out  = (wr_state == LSG_W_IDLE) && !w_held;
    assign s_axi_bvalid_out  = (wr_state == LSG_W_RESP);
    assign s_axi_bresp_out   = bresp;
    assign cur_addr  = aw_held ? aw_addr : s_axi_awaddr_in;
    assign cur_byte  = w_held ? w_byte : s_axi_wdata_in[7:0];
    assign cur_strb0 = w_held ? w_strb0 : s_axi_wstrb_in[0];
    assign do_write  = (wr_state == LSG_W_IDLE) && (aw_held || s_axi_awvalid_in) &&
                       (w_held || s_axi_wvalid_in);
    assign wr_map    = is_mapped(cur_addr);
    assign wr_hit    = do_write && wr_map && cur_strb0;
    // a read waits one cycle behind a write so the table pointer steps once
    assign s_axi_arready_out = (rd_state == LSG_R_IDLE) && !do_write;
    assign do_read   = s_axi_arvalid_in && s_axi_arready_out;
    assign rd_map    = is_mapped(s_axi_araddr_in);
    assign s_axi_rvalid_out = (rd_state == LSG_R_DATA);
    assign s_axi_rdata_out  = rdata;
    assign s_axi_rresp_out  = rresp;

    // write channel sequencing
    always_comb begin
        next_wr_state = wr_state;
        next_aw_held  = aw_held;
        next_aw_addr  = aw_addr;
        next_w_held   = w_held;
        next_w_byte   = w_byte;
        next_w_strb0  = w_strb0;
        next_bresp    = bresp;
        case (wr_state)
            LSG_W_IDLE: begin
                if (do_write) begin
                    next_aw_held  = 1'b0;
                    next_w_held   = 1'b0;
                    next_bresp    = wr_map ? RESP_OKAY : RESP_SLVERR;
                    next_wr_state = LSG_W_RESP;
                end else begin
                    if (s_axi_awvalid_in && !aw_held) begin
                        next_aw_held = 1'b1;
                        next_aw_addr = s_axi_awaddr_in;
                    end
                    if (s_axi_wvalid_in && !w_held) begin
                        next_w_held  = 1'b1;
                        next_w_byte  = s_axi_wdata_in[7:0];
                        next_w_strb0 = s_axi_wstrb_in[0];
                    end
                end
            end
            LSG_W_RESP: begin
                if (s_axi_bready_in) next_wr_state = LSG_W_IDLE;
            end
            default: next_wr_state = LSG_W_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            wr_state <= LSG_W_IDLE;
            aw_held  <= 1'b0;
            aw_addr  <= 8'h00;
            w_held   <= 1'b0;
            w_byte   <= 8'h00;
            w_strb0  <= 1'b0;
            bresp    <= RESP_OKAY;
        end else begin
            wr_state <= next_wr_state;
            aw_held  <= next_aw_held;
            aw_addr  <= next_aw_addr;
            w_held   <= next_w_held;
            w_byte   <= next_w_byte;
            w_strb0  <= next_w_strb0;
            bresp    <= next_bresp;
        end
    end

    // pin status: inputs show the pin, outputs show the driven value
    genvar g;
    generate
        for (g = 0; g < PIN_CNT; g++) begin : g_pin
            assign pin_own[g]    = upper_en && (g < UPPER_PINS);
            assign pin_status[g] = pin_dir[g] ? pin_val[g] : gpio_in[g];
            assign next_gpio_oe[g] = pin_dir[g] && !pin_own[g];
            assign next_gpio[g]    = pin_val[g] && next_gpio_oe[g];
        end
    endgenerate

    // read channel and readback mux
    always_comb begin
        next_rd_state = rd_state;
        next_rdata    = rdata;
        next_rresp    = rresp;
        case (rd_state)
            LSG_R_IDLE: begin
                if (do_read) begin
                    next_rd_state = LSG_R_DATA;
                    next_rresp    = rd_map ? RESP_OKAY : RESP_SLVERR;
                    next_rdata    = 32'h0000_0000;
                    case (s_axi_araddr_in[7:2])
                        IDX_PANEL_LO:    next_rdata[7:0] = panel_size[7:0];
                        IDX_PANEL_HI:    next_rdata[1:0] = panel_size[9:8];
                        IDX_LINE_OFFSET: next_rdata[7:0] = line_offset;
                        IDX_H1_LO:       next_rdata[7:0] = h1[7:0];
                        IDX_H1_HI:       next_rdata[1:0] = h1[9:8];
                        IDX_CT_INDEX:    next_rdata[7:0] = ct_index;
                        IDX_CT_DATA:     next_rdata[7:4] = lut_link.rdata;
                        IDX_PIN_DIR:     next_rdata[4:0] = pin_dir;
                        IDX_PIN_VAL:     next_rdata[4:0] = pin_status;
                        IDX_ROTATE:      next_rdata[7:0] = rotate;
                        IDX_PANEL_CFG:   next_rdata[UPPER_DATA_BIT] = upper_en;
                        default:         next_rdata = 32'h0000_0000;
                    endcase
                    if (!rd_map) next_rdata = 32'h0000_0000;
                end
            end
            LSG_R_DATA: begin
                if (s_axi_rready_in) next_rd_state = LSG_R_IDLE;
            end
            default: next_rd_state = LSG_R_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rd_state <= LSG_R_IDLE;
            rdata    <= 32'h0000_0000;
            rresp    <= RESP_OKAY;
        end else begin
            rd_state <= next_rd_state;
            rdata    <= next_rdata;
            rresp    <= next_rresp;
        end
    end

    // registers; unused bits dropped on write
    always_comb begin
        next_panel_size  = panel_size;
        next_line_offset = line_offset;
        next_h1          = h1;
        next_ct_index    = ct_index;
        next_pin_dir     = pin_dir;
        next_pin_val     = pin_val;
        next_rotate      = rotate;
        next_upper_en    = upper_en;
        if (wr_hit) begin
            case (cur_addr[7:2])
                IDX_PANEL_LO:    next_panel_size[7:0] = cur_byte;
                IDX_PANEL_HI:    next_panel_size[9:8] = cur_byte[1:0];
                IDX_LINE_OFFSET: next_line_offset = cur_byte;
                IDX_H1_LO:       next_h1[7:0] = cur_byte;
                IDX_H1_HI:       next_h1[9:8] = cur_byte[1:0];
                IDX_CT_INDEX:    next_ct_index = cur_byte;
                IDX_PIN_DIR:     next_pin_dir = cur_byte[4:0];
                IDX_PIN_VAL:     next_pin_val = cur_byte[4:0];
                IDX_ROTATE:      next_rotate = cur_byte & ROTATE_MASK;  // reserved bits stay 0
                IDX_PANEL_CFG:   next_upper_en = cur_byte[UPPER_DATA_BIT];
                default:         next_upper_en = upper_en;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            panel_size  <= RST_PANEL;
            line_offset <= RST_BYTE;
            h1          <= RST_H1;
            ct_index    <= RST_BYTE;
            pin_dir     <= 5'h00;
            pin_val     <= 5'h00;
            rotate      <= RST_BYTE;
            upper_en    <= 1'b0;
        end else begin
            panel_size  <= next_panel_size;
            line_offset <= next_line_offset;
            h1          <= next_h1;
            ct_index    <= next_ct_index;
            pin_dir     <= next_pin_dir;
            pin_val     <= next_pin_val;
            rotate      <= next_rotate;
            upper_en    <= next_upper_en;
        end
    end

    // colour table port requests
    assign lut_link.idx_wr  = wr_hit && (cur_addr[7:2] == IDX_CT_INDEX);
    assign lut_link.idx_val = cur_byte;
    assign lut_link.wr      = wr_hit && (cur_addr[7:2] == IDX_CT_DATA);
    assign lut_link.acc     = lut_link.wr ||
                              (do_read && rd_map && s_axi_araddr_in[7:2] == IDX_CT_DATA);
    assign lut_link.wdata   = cur_byte[7:CT_DATA_LSB];

    lsg_lut u_lut (
        .sys_clk_in    (sys_clk_in),
        .rst_n_in      (rst_n_in),
        .lut           (lut_link.tbl),
        .pix_index_in  (pix_index_in),
        .pix_red_out   (pix_red_out),
        .pix_green_out (pix_green_out),
        .pix_blue_out  (pix_blue_out)
    );

    // engine view; split lags the line input by one cycle
    always_comb begin
        next_line_gap = rotate[ROT_EN_BIT] ? 8'h00 : line_offset;
        // split only in landscape when the height is below panel size
        next_screen2  = !rotate[ROT_EN_BIT] && (h1 < panel_size) &&
                        (disp_line_in > h1);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            line_gap_out    <= 8'h00;
            rotate_en_out   <= 1'b0;
            screen2_sel_out <= 1'b0;
            gpio_out        <= 5'h00;
            gpio_oe_out     <= 5'h00;
            panel_data_upper_bits_en_out <= 1'b0;
        end else begin
            line_gap_out    <= next_line_gap;
            rotate_en_out   <= rotate[ROT_EN_BIT];
            screen2_sel_out <= next_screen2;
            gpio_out        <= next_gpio;
            gpio_oe_out     <= next_gpio_oe;
            panel_data_upper_bits_en_out <= upper_en;
        end
    end
endmodule : lsg_regs

// File: rtl/lsg_pkg.sv
// constants, field layout and state types for the split/lut/pin register bank
package lsg_pkg;
    localparam int ADDR_W = 8;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_PANEL_LO    = 6'h05;
    localparam logic [5:0] IDX_PANEL_HI    = 6'h06;
    localparam logic [5:0] IDX_LINE_OFFSET = 6'h11;
    localparam logic [5:0] IDX_H1_LO       = 6'h12;
    localparam logic [5:0] IDX_H1_HI       = 6'h13;
    localparam logic [5:0] IDX_CT_INDEX    = 6'h15;
    localparam logic [5:0] IDX_CT_DATA     = 6'h17;
    localparam logic [5:0] IDX_PIN_DIR     = 6'h18;
    localparam logic [5:0] IDX_PIN_VAL     = 6'h19;
    localparam logic [5:0] IDX_ROTATE      = 6'h1b;
    localparam logic [5:0] IDX_PANEL_CFG   = 6'h20;
    // field positions and widths
    localparam int ROT_EN_BIT     = 7;
    localparam int CT_DATA_LSB    = 4;
    localparam int PIN_CNT        = 5;
    localparam int UPPER_PINS     = 4;
    localparam int UPPER_DATA_BIT = 0;
    localparam logic [7:0] ROTATE_MASK = 8'hc3;
    // reset values
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [9:0] RST_H1    = 10'h3ff;
    localparam logic [9:0] RST_PANEL = 10'h000;
    localparam logic [3:0] RST_NIB   = 4'h0;
    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {LSG_W_IDLE = 2'b01, LSG_W_RESP = 2'b10} lsg_wr_state_e;
    typedef enum logic [1:0] {LSG_R_IDLE = 2'b01, LSG_R_DATA = 2'b10} lsg_rd_state_e;
    typedef enum logic [2:0] {LSG_RED = 3'b001, LSG_GREEN = 3'b010, LSG_BLUE = 3'b100} lsg_colour_e;
endpackage : lsg_pkg

// File: rtl/lsg_lut_if.sv
// link between the register front end and the colour table store
`timescale 1ns/1ps
interface lsg_lut_if;
    logic       idx_wr;   // index register written
    logic [7:0] idx_val;  // written index
    logic       acc;      // data port read or write
    logic       wr;       // data port write
    logic [3:0] wdata;    // written component
    logic [3:0] rdata;    // component at pointer
    modport ctl (output idx_wr, idx_val, acc, wr, wdata, input rdata);
    modport tbl (input idx_wr, idx_val, acc, wr, wdata, output rdata);
endinterface : lsg_lut_if

// File: rtl/lsg_lut.sv
// three colour tables with auto-stepping access pointer and staged commit
`timescale 1ns/1ps
module lsg_lut
    import lsg_pkg::*;
(
    input  wire logic       sys_clk_in,     // system clock
    input  wire logic       rst_n_in,       // sync reset, active low
    lsg_lut_if.tbl          lut,            // host access side
    input  wire logic [7:0] pix_index_in,   // display lookup index
    output logic      [3:0] pix_red_out,    // red entry
    output logic      [3:0] pix_green_out,  // green entry
    output logic      [3:0] pix_blue_out    // blue entry
);
    logic [3:0]  red_tbl [256];
    logic [3:0]  grn_tbl [256];
    logic [3:0]  blu_tbl [256];
    logic [7:0]  ptr_idx, next_ptr_idx;
    lsg_colour_e ptr_col, next_ptr_col;
    logic [3:0]  red_stage, next_red_stage;
    logic [3:0]  grn_stage, next_grn_stage;
    logic        commit;

    // pointer stepping and staging; an index write wins over a data access
    always_comb begin
        next_ptr_idx   = ptr_idx;
        next_ptr_col   = ptr_col;
        next_red_stage = red_stage;
        next_grn_stage = grn_stage;
        commit         = 1'b0;
        if (lut.idx_wr) begin
            next_ptr_idx = lut.idx_val;
            next_ptr_col = LSG_RED;
        end else if (lut.acc) begin
            case (ptr_col)
                LSG_RED: begin
                    next_ptr_col = LSG_GREEN;
                    if (lut.wr) next_red_stage = lut.wdata;
                end
                LSG_GREEN: begin
                    next_ptr_col = LSG_BLUE;
                    if (lut.wr) next_grn_stage = lut.wdata;
                end
                LSG_BLUE: begin
                    next_ptr_col = LSG_RED;
                    next_ptr_idx = ptr_idx + 8'h01;
                    commit       = lut.wr;
                end
                default: next_ptr_col = LSG_RED;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ptr_idx   <= 8'h00;
            ptr_col   <= LSG_RED;
            red_stage <= RST_NIB;
            grn_stage <= RST_NIB;
        end else begin
            ptr_idx   <= next_ptr_idx;
            ptr_col   <= next_ptr_col;
            red_stage <= next_red_stage;
            grn_stage <= next_grn_stage;
        end
    end

    // tables have no reset; undefined until loaded
    always_ff @(posedge sys_clk_in) begin
        if (commit) begin
            red_tbl[ptr_idx] <= red_stage;
            grn_tbl[ptr_idx] <= grn_stage;
            blu_tbl[ptr_idx] <= lut.wdata;
        end
        pix_red_out   <= red_tbl[pix_index_in];
        pix_green_out <= grn_tbl[pix_index_in];
        pix_blue_out  <= blu_tbl[pix_index_in];
    end

    // readback shows committed entries, not staging
    always_comb begin
        case (ptr_col)
            LSG_RED:   lut.rdata = red_tbl[ptr_idx];
            LSG_GREEN: lut.rdata = grn_tbl[ptr_idx];
            LSG_BLUE:  lut.rdata = blu_tbl[ptr_idx];
            default:   lut.rdata = RST_NIB;
        endcase
    end
endmodule : lsg_lut

// File: tb/lsg_checker.sv
// register bank port checks
`timescale 1ns/1ps
module lsg_checker
    import lsg_pkg::*;
(
    input wire logic        sys_clk_in,                  // system clock
    input wire logic        rst_n_in,                    // sync reset, active low
    input wire logic        s_axi_bvalid_out,            // write response valid
    input wire logic        s_axi_bready_in,             // write response ready
    input wire logic [1:0]  s_axi_bresp_out,             // write response
    input wire logic        s_axi_arvalid_in,            // read address valid
    input wire logic        s_axi_arready_out,           // read address ready
    input wire logic        s_axi_rvalid_out,            // read data valid
    input wire logic        s_axi_rready_in,             // read data ready
    input wire logic [31:0] s_axi_rdata_out,             // read data
    input wire logic [9:0]  disp_line_in,                // panel line
    input wire logic [7:0]  line_gap_out,                // line offset in use
    input wire logic        rotate_en_out,               // rotated mode
    input wire logic        screen2_sel_out,             // screen 2 line
    input wire logic [4:0]  gpio_out,                    // pin drive values
    input wire logic [4:0]  gpio_oe_out,                 // pin enables
    input wire logic        panel_data_upper_bits_en_out // pins 3-0 to panel
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // rotated mode, split, pin and bus checks
    gap_rot_a: assert property (rotate_en_out |-> line_gap_out == 8'h00)
        else $error("line gap nonzero while rotated");
    split_rot_a: assert property (rotate_en_out && $past(rotate_en_out) |-> !screen2_sel_out)
        else $error("split while rotated");
    split_line_a: assert property (screen2_sel_out |-> $past(disp_line_in) != 10'h000)
        else $error("line 0 in screen 2");
    pin_out_a: assert property ((gpio_out & ~gpio_oe_out) == 5'h00)
        else $error("pin driven without enable");
    pin_upper_a: assert property (panel_data_upper_bits_en_out
        && $past(panel_data_upper_bits_en_out) |-> gpio_oe_out[3:0] == 4'h0)
        else $error("panel pin driven");
    resp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
        s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
        s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
    rd_lat_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read answer late");
    rd_upper_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
        else $error("rdata upper bits set");
    // scenarios
    cover property (screen2_sel_out);
    cover property (rotate_en_out);
    cover property (s_axi_bvalid_out && s_axi_bresp_out == RESP_SLVERR);
endmodule : lsg_checker
bind lsg_regs lsg_checker lsg_checker_i (.*);

// File: tb/lsg_engine_model.sv
// display engine and pin pull-ups
`timescale 1ns/1ps
module lsg_engine_model (
    input  wire logic       sys_clk_in,   // system clock
    input  wire logic       rst_n_in,     // sync reset, active low
    input  wire logic [4:0] gpio_drv_in,  // bank pin drive
    input  wire logic [4:0] gpio_oe_in,   // bank pin enable
    output logic      [4:0] gpio_lvl_out, // pin levels
    output logic      [9:0] line_out      // scanned panel line
);
    // undriven pin pulled up
    assign gpio_lvl_out = (gpio_drv_in & gpio_oe_in) | ~gpio_oe_in;
    // sweep a 16 line panel
    always_ff @(posedge sys_clk_in) begin
        line_out <= !rst_n_in ? 10'h000 : (line_out + 10'h001) & 10'h00f;
    end
endmodule : lsg_engine_model

// File: tb/lsg_regs_test.sv
// register bank test
`timescale 1ns/1ps
module lsg_regs_test;
    import lsg_pkg::*;
    logic        clk = 0, rst_n = 0, awv = 0, wv = 0, arv = 0, bready = 0, rready = 0;
    logic [7:0]  awa = 8'h00, ara = 8'h00, pix = 8'h00, gap;
    logic [31:0] wd = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    logic [9:0]  ln, lq;
    logic [4:0]  lvl, gout, goe;
    logic [3:0]  pr, pg, pb;
    logic        awr, wrd, bv, arr, rv, rot, s2, upe;
    int          error_cnt = 0, tests_run = 0, cyc = 0;
    localparam logic [7:0] CTV [6] = '{8'ha5, 8'hb0, 8'hc0, 8'h10, 8'h20, 8'h30};
    always #4 clk = ~clk;
    lsg_regs lsg_regs_i (.sys_clk_in(clk), .rst_n_in(rst_n), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wrd), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'h1),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .disp_line_in(ln), .line_gap_out(gap), .rotate_en_out(rot),
        .screen2_sel_out(s2), .pix_index_in(pix), .pix_red_out(pr), .pix_green_out(pg),
        .pix_blue_out(pb), .gpio_in(lvl), .gpio_out(gout), .gpio_oe_out(goe),
        .panel_data_upper_bits_en_out(upe));
    lsg_engine_model lsg_engine_model_i (.sys_clk_in(clk), .rst_n_in(rst_n),
        .gpio_drv_in(gout), .gpio_oe_in(goe), .gpio_lvl_out(lvl), .line_out(ln));
    task automatic stop_test();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // write: aw and w together
    task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        @(posedge clk);
        awv <= 1'b1;
        wv <= 1'b1;
        awa <= {i, 2'b00};
        wd <= {24'h0, d};
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv);
        bready <= 1'b1;
        @(posedge clk);
        bready <= 1'b0;
        chk("bresp", {6'h0, er}, {6'h0, bresp});
    endtask : wr
    // read: rready after rvalid
    task automatic rd(input logic [5:0] i, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
        @(posedge clk);
        arv <= 1'b1;
        ara <= {i, 2'b00};
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        rready <= 1'b1;
        @(posedge clk);
        rready <= 1'b0;
        chk("rdata", e, rdata[7:0]);
        chk("rresp", {6'h0, er}, {6'h0, rresp});
    endtask : rd
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            error_cnt++;
            stop_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(IDX_H1_LO, 8'hff);
        rd(IDX_H1_HI, 8'h03);
        wr(6'h3f, 8'h11, RESP_SLVERR);
        rd(6'h3f, 8'h00, RESP_SLVERR);
        wr(IDX_H1_HI, 8'hfe);
        rd(IDX_H1_HI, 8'h02);
        wr(IDX_H1_HI, 8'h00);
        wr(IDX_PANEL_LO, 8'h0f);
        // split at 5, then none
        for (int k = 0; k < 2; k++) begin
            wr(IDX_H1_LO, k == 0 ? 8'h05 : 8'h0f);
            @(posedge clk);
            lq = ln;
            repeat (20) begin
                @(posedge clk);
                chk("screen2", {7'h0, k == 0 && lq > 10'd5}, {7'h0, s2});
                lq = ln;
            end
        end
        wr(IDX_LINE_OFFSET, 8'h07);
        wr(IDX_ROTATE, 8'h80);
        repeat (2) @(posedge clk);
        chk("rotate", 8'h01, {7'h0, rot});
        chk("gap", 8'h00, gap);
        wr(IDX_ROTATE, 8'h00);
        repeat (2) @(posedge clk);
        chk("gap", 8'h07, gap);
        wr(IDX_CT_INDEX, 8'hff);
        for (int k = 0; k < 6; k++) wr(IDX_CT_DATA, CTV[k]);
        wr(IDX_CT_INDEX, 8'hff);
        for (int k = 0; k < 4; k++) rd(IDX_CT_DATA, CTV[k] & 8'hf0);
        wr(IDX_CT_INDEX, 8'h00);
        wr(IDX_CT_DATA, 8'h90);
        wr(IDX_CT_INDEX, 8'h00);
        rd(IDX_CT_DATA, 8'h10);
        rd(IDX_CT_INDEX, 8'h00);
        pix <= 8'hff;
        repeat (2) @(posedge clk);
        chk("pix", 8'hab, {pr, pg});
        chk("pix_blue", 8'h0c, {4'h0, pb});
        wr(IDX_PIN_DIR, 8'h03);
        wr(IDX_PIN_VAL, 8'h01);
        rd(IDX_PIN_VAL, 8'h1d);
        chk("pin_oe", 8'h03, {3'h0, goe});
        chk("pin_out", 8'h01, {3'h0, gout});
        wr(IDX_PANEL_CFG, 8'h01);
        wr(IDX_PIN_DIR, 8'h1f);
        repeat (2) @(posedge clk);
        chk("pin_oe", 8'h10, {3'h0, goe});
        stop_test();
    end
endmodule : lsg_regs_test
